// [bench/sfc_frame_ctrl_tb_top.sv]
// Testbench of the converter frame control
`timescale 1ns/10ps
`default_nettype none

module sfc_frame_ctrl_tb_top;
  import sfc_pkg::*;

  logic        mclk;
  logic        rst;
  logic        cs_n;
  logic        fs;
  logic        sclk;
  logic        out_s;
  logic        oe_s;
  logic        sel_s;
  logic        sel_d;
  logic        samp;
  logic        conv;
  logic        pwr;
  logic        conv_seen;
  logic [11:0] code;
  logic [11:0] prev_code;
  int          n_mismatch;
  int          comparisons;
  int          cycles;
  int          samp_cnt;

  sfc_frame_ctrl #(.VARIANT(SFC_SINGLE), .CONV_CYC(20)) u_sfc_frame_ctrl (
    .MCLK(mclk), .RST(rst), .CHIP_SELECT_N(cs_n), .FRAME_SYNC(fs), .SCLK(sclk),
    .SERIAL_RESULT_OUT(out_s), .SERIAL_RESULT_OE(oe_s), .CONV_CODE(code),
    .INPUT_SELECTOR(sel_s), .SAMPLING(samp), .CONVERTING(conv), .POWERED_UP(pwr));

  sfc_frame_ctrl #(.VARIANT(SFC_DUAL), .CONV_CYC(20)) u_sfc_frame_ctrl_dual (
    .MCLK(mclk), .RST(rst), .CHIP_SELECT_N(cs_n), .FRAME_SYNC(fs), .SCLK(sclk),
    .SERIAL_RESULT_OUT(), .SERIAL_RESULT_OE(), .CONV_CODE(code),
    .INPUT_SELECTOR(sel_d), .SAMPLING(), .CONVERTING(), .POWERED_UP());

  sfc_host u_sfc_host (
    .mclk(mclk), .chip_select_n(cs_n), .frame_sync(fs), .sclk(sclk),
    .sdo_out(out_s), .sdo_oe(oe_s));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (samp === 1'b1)
      samp_cnt++;
    if (conv === 1'b1)
      conv_seen = 1'b1;
    if (cycles == 6000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Full frame: previous code shifted out, then this code converted
  // Mode 0: select only, 1: select and frame-sync, 2: frame-sync only
  task automatic frame(input int mode, input logic [11:0] new_code);
    logic [15:0] w;
    logic        oe_end;
    code      = new_code;
    samp_cnt  = 0;
    conv_seen = 1'b0;
    if (mode == 2)
      u_sfc_host.fs_cycle(40, w, oe_end);
    else
      u_sfc_host.cycle(mode == 1, 16, 40, w, oe_end);
    check("result bits", {4'h0, w[15:4]}, {4'h0, prev_code});
    check("oe after last fall", {15'h0000, oe_end}, 16'h0000);
    check("oe deselected", {15'h0000, oe_s}, 16'h0000);
    check("sampling cycles", samp_cnt[15:0], 16'h0084);
    check("conversion ran", {15'h0000, conv_seen}, 16'h0001);
    check("power down", {15'h0000, pwr}, 16'h0000);
    check("single selector", {15'h0000, sel_s}, 16'h0000);
    prev_code = new_code;
  endtask

  task automatic test_fs_only();
    frame(2, 12'h3c6);
    frame(2, 12'hc39);
  endtask

  task automatic test_cs_only();
    frame(1'b0, 12'hfff);
    frame(1'b0, 12'h000);
  endtask

  task automatic test_cs_fs();
    frame(1'b1, 12'ha5c);
    frame(1'b1, 12'h5a3);
  endtask

  // Selector after chip-select low periods of several lengths
  task automatic test_selector();
    int          nf [6] = '{16, 5, 16, 3, 7, 8};
    logic        ex [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    logic [15:0] w;
    logic        oe_end;
    for (int i = 0; i < 6; i++) begin
      u_sfc_host.cycle(1'b0, nf[i], (nf[i] == 16) ? 40 : 4, w, oe_end);
      check("selector", {15'h0000, sel_d}, {15'h0000, ex[i]});
    end
  endtask

  initial begin
    rst         = 1'b1;
    code        = 12'h000;
    prev_code   = 12'h000;
    conv_seen   = 1'b0;
    n_mismatch  = 0;
    comparisons = 0;
    cycles      = 0;
    samp_cnt    = 0;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    test_cs_only();
    test_cs_fs();
    test_selector();
    test_fs_only();
    report_and_stop();
  end
endmodule

`default_nettype wire

// [bench/sfc_host.sv]
// Host serial port model driving the converter link
`timescale 1ns/10ps
`default_nettype none

module sfc_host (
  // Clock
  input  wire logic mclk,
  // Link
  output var  logic chip_select_n,
  output var  logic frame_sync,
  output var  logic sclk,
  input  wire logic sdo_out,
  input  wire logic sdo_oe
);
  logic last = 1'b0;
  logic serial_result_out;

  // A released pin shows the inverse of the last driven value
  assign serial_result_out = sdo_oe ? sdo_out : ~last;

  always @(posedge mclk) begin
    if (sdo_oe)
      last <= sdo_out;
  end

  initial begin
    chip_select_n = 1'b1;
    frame_sync    = 1'b1;
    sclk          = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Clock idles low; data taken at each falling clock edge
  task automatic cycle(input bit fs_mode, input int nfalls, input int tail,
                       output logic [15:0] word, output logic oe_end);
    word = 16'h0000;
    sclk = 1'b1;
    tick(6);
    sclk = 1'b0;
    tick(6);
    frame_sync = !fs_mode;
    tick(1);
    chip_select_n = 1'b0;
    tick(6);
    if (fs_mode) begin
      frame_sync = 1'b1;
      tick(6);
      sclk = 1'b1;
      tick(3);
      frame_sync = 1'b0;
      tick(3);
    end
    for (int k = 0; k < nfalls; k++) begin
      if (!(fs_mode && k == 0)) begin
        sclk = 1'b1;
        tick(6);
      end
      word = {word[14:0], serial_result_out};
      sclk = 1'b0;
      tick(6);
    end
    oe_end = sdo_oe;
    tick(tail);
    chip_select_n = 1'b1;
    frame_sync    = 1'b1;
    tick(6);
  endtask

  // Frame-sync only: select stays low, frame-sync spans one clock fall
  task automatic fs_cycle(input int tail, output logic [15:0] word, output logic oe_end);
    word = 16'h0000;
    frame_sync = 1'b0;
    tick(1);
    chip_select_n = 1'b0;
    tick(6);
    frame_sync = 1'b1;
    tick(6);
    sclk = 1'b1;
    tick(6);
    sclk = 1'b0;
    tick(6);
    sclk = 1'b1;
    tick(3);
    frame_sync = 1'b0;
    tick(3);
    for (int k = 0; k < 16; k++) begin
      if (k != 0) begin
        sclk = 1'b1;
        tick(6);
      end
      word = {word[14:0], serial_result_out};
      sclk = 1'b0;
      tick(6);
    end
    oe_end = sdo_oe;
    tick(tail);
  endtask
endmodule

`default_nettype wire

// [rtl/sfc_defs.svh]
// Constants of the serial converter frame control
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH

// Frame layout
`define SFC_FRAME_BITS   16
`define SFC_CODE_BITS    12
`define SFC_PAD          4'h0
`define SFC_CODE_ZERO    12'h000
`define SFC_CODE_FULL    12'hfff

// Falling serial clock counts within a frame
`define SFC_FALL_LAST    5'h10
`define SFC_SAMP_FIRST   5'h05
`define SFC_FALL_ONE     5'h01

// Chip-select low length, in serial clocks, for the selector
`define SFC_SEL_RST_MIN  4'h4
`define SFC_SEL_RST_MAX  4'h7
`define SFC_LCNT_SAT     4'hf

// Conversion time and clock period
`define SFC_CONV_NS      3500
`define SFC_MCLK_NS      4

// Buffer
`define SFC_BUF_DEPTH    2'h2

`endif

// [rtl/sfc_frame_ctrl.sv]
// Serial control, output framing and input selector of a 12-bit converter
// Operation
// - Output is high impedance while chip-select is high, driven from its fall.
// - Frame shifts MSB first; output released after the sixteenth serial clock.
// - Bits change on rising serial clock; host samples on the falling edge.
// - Frame holds the 12-bit result in upper bits, four low bits don't-care.
// - Code is unsigned binary, 000h at ground, FFFh at full scale.
// - Control inputs latched on a serial clock fall while chip-select is high.
// - Chip-select-only mode: falling chip-select starts the cycle, MSB read first fall.
// - Frame-sync-only: MSB after frame-sync rises, falling frame-sync starts cycle.
// - Both used: MSB after chip-select falls, frame-sync fall starts cycle.
// - Dual and differential variants are controlled by chip-select alone.
// - Dual variant: chip-select low four to seven clocks resets selector.
// - Dual variant: chip-select low over seven clocks toggles the selector.
// - Sampling lasts eleven serial clocks, starting at the fifth fall.
// - Conversion starts after the sixteenth fall and ends within 3.5 us.
// - Data shifted out is the result of the previous cycle's sample.
// - Power down after conversion, wake on chip-select fall or frame-sync rise.
`include "sfc_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module sfc_frame_ctrl
  import sfc_pkg::*;
#(
  parameter sfc_var_e VARIANT  = SFC_SINGLE,
  parameter int       DW       = `SFC_CODE_BITS,
  parameter int       CONV_CYC = `SFC_CONV_NS / `SFC_MCLK_NS
) (
  // Clock and reset
  input  wire logic          MCLK,
  input  wire logic          RST,
  // Serial link from the host
  input  wire logic          CHIP_SELECT_N,
  input  wire logic          FRAME_SYNC,
  input  wire logic          SCLK,
  output var  logic          SERIAL_RESULT_OUT,
  output var  logic          SERIAL_RESULT_OE,
  // Converter core
  input  wire logic [DW-1:0] CONV_CODE,
  output var  logic          INPUT_SELECTOR,
  output var  logic          SAMPLING,
  output var  logic          CONVERTING,
  output var  logic          POWERED_UP
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detection

  logic       cs_m, cs_s, cs_d;
  logic       fs_m, fs_s, fs_d;
  logic       ck_m, ck_s, ck_d;
  logic       cs_fall, cs_rise, fs_fall, fs_rise, sclk_fall, sclk_rise;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
      fs_m <= 1'b1;
      fs_s <= 1'b1;
      fs_d <= 1'b1;
      ck_m <= 1'b0;
      ck_s <= 1'b0;
      ck_d <= 1'b0;
    end else begin
      cs_m <= CHIP_SELECT_N;
      cs_s <= cs_m;
      cs_d <= cs_s;
      fs_m <= FRAME_SYNC;
      fs_s <= fs_m;
      fs_d <= fs_s;
      ck_m <= SCLK;
      ck_s <= ck_m;
      ck_d <= ck_s;
    end
  end

  assign cs_fall   = cs_d & ~cs_s;
  assign cs_rise   = ~cs_d & cs_s;
  assign fs_fall   = fs_d & ~fs_s;
  assign fs_rise   = ~fs_d & fs_s;
  assign sclk_fall = ck_d & ~ck_s;
  assign sclk_rise = ~ck_d & ck_s;

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry result buffer between converter and shifter

  logic [DW-1:0] mem [2];
  logic [DW-1:0] last, next_last, word;
  logic [1:0]    cnt, next_cnt;
  logic          wp, rp, next_wp, next_rp;
  logic          push_v, push_rdy, pop_v, pop_rdy, load;

  assign push_rdy = (cnt != `SFC_BUF_DEPTH);
  assign pop_v    = (cnt != 2'h0);
  assign pop_rdy  = load;
  assign word     = pop_v ? mem[rp] : last;

  always_comb begin
    next_cnt  = cnt;
    next_wp   = wp;
    next_rp   = rp;
    next_last = last;
    if (push_v && push_rdy) begin
      next_wp = ~wp;
    end
    if (pop_v && pop_rdy) begin
      next_rp   = ~rp;
      next_last = mem[rp];
    end
    next_cnt = cnt + {1'b0, push_v && push_rdy} - {1'b0, pop_v && pop_rdy};
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cnt  <= 2'h0;
      wp   <= 1'b0;
      rp   <= 1'b0;
      last <= '0;
    end else begin
      cnt  <= next_cnt;
      wp   <= next_wp;
      rp   <= next_rp;
      last <= next_last;
    end
  end

  // Result code is taken unchanged: unsigned straight binary
  always_ff @(posedge MCLK) begin
    if (push_v && push_rdy) begin
      mem[wp] <= CONV_CODE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame control, shifter and input selector

  sfc_state_e st, next_st;
  logic [`SFC_FRAME_BITS-1:0] sh, next_sh;
  logic [4:0] fcnt, next_fcnt, fcnt_inc;
  logic [3:0] lcnt, next_lcnt;
  logic [9:0] ccnt, next_ccnt;
  logic       armed, next_armed, oe, next_oe, sel, next_sel;
  logic       samp, next_samp, pwr, next_pwr, conv, next_conv, start;
  logic       fs_ctl;

  assign fs_ctl   = (VARIANT == SFC_SINGLE);
  assign fcnt_inc = fcnt + `SFC_FALL_ONE;

  always_comb begin
    next_st    = st;
    next_sh    = sh;
    next_fcnt  = fcnt;
    next_lcnt  = lcnt;
    next_ccnt  = ccnt;
    next_armed = armed;
    next_oe    = oe;
    next_sel   = sel;
    next_samp  = samp;
    load       = 1'b0;
    start      = 1'b0;
    push_v     = 1'b0;
    if (sclk_fall && !cs_s && lcnt != `SFC_LCNT_SAT) begin
      next_lcnt = lcnt + 4'h1;
    end
    if (cs_fall) begin
      next_lcnt = 4'h0;
      load      = 1'b1;
      if (!fs_ctl || fs_s) begin
        start = armed;
      end
    end
    if (fs_ctl && !cs_s) begin
      if (fs_rise && !oe) begin
        load = 1'b1;
      end
      if (fs_fall && st != SFC_ACT) begin
        start = armed;
      end
    end
    if (cs_rise) begin
      next_oe = 1'b0;
      // Select rising mid-frame abandons the frame
      if (st == SFC_ACT) begin
        next_st   = SFC_SLEEP;
        next_samp = 1'b0;
      end
      if (VARIANT == SFC_DUAL) begin
        if (lcnt > `SFC_SEL_RST_MAX) begin
          next_sel = ~sel;
        end else if (lcnt >= `SFC_SEL_RST_MIN) begin
          next_sel = 1'b0;
        end
      end
    end
    if (st == SFC_ACT && sclk_fall) begin
      next_fcnt = fcnt_inc;
      next_samp = (fcnt_inc >= `SFC_SAMP_FIRST) && (fcnt_inc < `SFC_FALL_LAST);
      if (fcnt_inc == `SFC_FALL_LAST) begin
        next_oe   = 1'b0;
        next_st   = SFC_CONV;
        next_ccnt = 10'h000;
      end
    end
    // Shift only after the first fall so the MSB is seen by it
    if (sclk_rise && oe && fcnt != 5'h00) begin
      next_sh = {sh[`SFC_FRAME_BITS-2:0], 1'b0};
    end
    if (st == SFC_CONV) begin
      if (ccnt != 10'(CONV_CYC - 1)) begin
        next_ccnt = ccnt + 10'h001;
      end else if (push_rdy) begin
        push_v  = 1'b1;
        next_st = SFC_SLEEP;
      end
    end
    if (load) begin
      next_sh   = {word, `SFC_PAD};
      next_oe   = 1'b1;
      next_fcnt = 5'h00;
    end
    if (start) begin
      next_st    = SFC_ACT;
      next_armed = 1'b0;
      next_fcnt  = 5'h00;
      next_samp  = 1'b0;
    end
    // Latch wins over the clear of a coincident start; in the single variant frame-sync high also latches outside a frame
    if (sclk_fall && (cs_s || (fs_ctl && fs_s && st != SFC_ACT))) begin
      next_armed = 1'b1;
    end
    next_pwr  = (next_st != SFC_SLEEP) || next_oe;
    next_conv = (next_st == SFC_CONV);
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      st    <= SFC_SLEEP;
      sh    <= '0;
      fcnt  <= 5'h00;
      lcnt  <= 4'h0;
      ccnt  <= 10'h000;
      armed <= 1'b0;
      oe    <= 1'b0;
      sel   <= 1'b0;
      samp  <= 1'b0;
      pwr   <= 1'b0;
      conv  <= 1'b0;
    end else begin
      st    <= next_st;
      sh    <= next_sh;
      fcnt  <= next_fcnt;
      lcnt  <= next_lcnt;
      ccnt  <= next_ccnt;
      armed <= next_armed;
      oe    <= next_oe;
      sel   <= next_sel;
      samp  <= next_samp;
      pwr   <= next_pwr;
      conv  <= next_conv;
    end
  end

  assign SERIAL_RESULT_OUT = sh[`SFC_FRAME_BITS-1];
  assign SERIAL_RESULT_OE  = oe;
  assign INPUT_SELECTOR    = sel;
  assign SAMPLING          = samp;
  assign CONVERTING        = conv;
  assign POWERED_UP        = pwr;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);

  property p_hiz_cs;
    cs_s |=> !oe;
  endproperty
  a_hiz_cs: assert property (p_hiz_cs) else $error("output driven with select high");

  property p_frame_end;
    st == SFC_ACT && sclk_fall && fcnt == 5'h0f && !load
      |=> !oe && st == SFC_CONV && ccnt == 10'h000;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame not ended at 16th fall");

  property p_shift_rise;
    oe && $past(oe) && !$past(load) && sh != $past(sh) |-> $past(sclk_rise);
  endproperty
  a_shift_rise: assert property (p_shift_rise) else $error("shift without rising clock");

  property p_frame_fmt;
    load |=> sh == {$past(word), `SFC_PAD} && oe && fcnt == 5'h00;
  endproperty
  a_frame_fmt: assert property (p_frame_fmt) else $error("frame load wrong");

  property p_samp_win;
    st == SFC_ACT && sclk_fall && !start && !load
      |=> samp == ($past(fcnt) >= 5'h04 && $past(fcnt) < 5'h0f);
  endproperty
  a_samp_win: assert property (p_samp_win) else $error("sampling window wrong");

  property p_sel_reset;
    VARIANT == SFC_DUAL && cs_rise && lcnt >= `SFC_SEL_RST_MIN && lcnt <= `SFC_SEL_RST_MAX
      |=> !sel;
  endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("selector not reset");

  property p_sel_toggle;
    VARIANT == SFC_DUAL && cs_rise && lcnt > `SFC_SEL_RST_MAX |=> sel != $past(sel);
  endproperty
  a_sel_toggle: assert property (p_sel_toggle) else $error("selector not toggled");

  property p_pdown;
    push_v && !start |=> st == SFC_SLEEP && !conv;
  endproperty
  a_pdown: assert property (p_pdown) else $error("no power down after conversion");

  property p_armed;
    st == SFC_ACT && $past(st) != SFC_ACT |-> $past(armed) && !armed;
  endproperty
  a_armed: assert property (p_armed) else $error("cycle started without control latch");

endmodule

`default_nettype wire

// [rtl/sfc_pkg.sv]
// Types of the serial converter frame control
package sfc_pkg;

  typedef enum logic [1:0] {
    SFC_SLEEP = 2'b00,
    SFC_ACT   = 2'b01,
    SFC_CONV  = 2'b10
  } sfc_state_e;

  typedef enum logic [1:0] {
    SFC_SINGLE = 2'b00,
    SFC_DUAL   = 2'b01,
    SFC_PDIFF  = 2'b10
  } sfc_var_e;

endpackage
